//--- icsr_pkg.sv
package icsr_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [3:0] ICSR_OFF_CONTROL = 4'h0;
	localparam logic [3:0] ICSR_OFF_STATUS = 4'h4;
	localparam logic [3:0] ICSR_OFF_RELOAD = 4'h8;
	localparam int ICSR_ADDR_W = 4;

	// ****************************************
	// control word fields
	// ****************************************
	localparam int ICSR_CTL_SHADOW_BIT = 16;
	localparam int ICSR_CTL_HALT_BIT = 14;
	localparam int ICSR_CTL_MULTI_BIT = 12;
	localparam int ICSR_CTL_THR_LSB = 8;
	localparam int ICSR_CTL_EDGE_LSB = 0;
	localparam int ICSR_NUM_EXT = 5;

	// ****************************************
	// status word fields
	// ****************************************
	localparam int ICSR_STAT_LEVEL_LSB = 8;
	localparam int ICSR_STAT_INDEX_LSB = 0;
	localparam int ICSR_PRIO_W = 3;
	localparam int ICSR_VEC_W = 6;

	// ****************************************
	// reset values and responses
	// ****************************************
	localparam logic [31:0] ICSR_RST_WORD = 32'h0000_0000;
	localparam logic [2:0] ICSR_THR_OFF = 3'h0;
	localparam logic [1:0] ICSR_RESP_OKAY = 2'h0;
	localparam logic [1:0] ICSR_RESP_SLVERR = 2'h2;
	localparam logic [31:0] ICSR_TMR_ONE = 32'h0000_0001;

	typedef enum logic [1:0] {
		ICSR_TMR_IDLE = 2'b00,
		ICSR_TMR_COUNT = 2'b01,
		ICSR_TMR_PASS = 2'b10
	} icsr_tmr_e;

endpackage

//--- icsr_edge_detect.sv
`timescale 1ns/1ps
module icsr_edge_detect import icsr_pkg::*; (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic [ICSR_NUM_EXT-1:0] i_pins,
	input wire logic [ICSR_NUM_EXT-1:0] i_rising_sel,
	output logic [ICSR_NUM_EXT-1:0] o_event
);

	// ****************************************
	// per input synchroniser and edge select
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < ICSR_NUM_EXT; g = g + 1) begin : g_ch
			logic meta_q, meta_d, sync_q, sync_d, prev_q, prev_d, ev_q, ev_d;
			always_comb begin
				meta_d = i_pins[g];
				sync_d = meta_q;
				prev_d = sync_q;
				// rising when select is one, falling when zero
				ev_d = i_rising_sel[g] ? (sync_q & ~prev_q) : (~sync_q & prev_q);
			end
			always_ff @(posedge i_clock) begin
				if (i_srst) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
					prev_q <= 1'b0;
					ev_q <= 1'b0;
				end else begin
					meta_q <= meta_d;
					sync_q <= sync_d;
					prev_q <= prev_d;
					ev_q <= ev_d;
				end
			end
			assign o_event[g] = ev_q;
		end
	endgenerate

endmodule

//--- icsr_prox_timer.sv
`timescale 1ns/1ps
module icsr_prox_timer import icsr_pkg::*; (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_run,
	input wire logic [ICSR_PRIO_W-1:0] i_threshold,
	input wire logic [31:0] i_reload,
	input wire logic i_req_valid,
	input wire logic [ICSR_PRIO_W-1:0] i_req_priority,
	output logic o_hold,
	output logic o_busy
);

	icsr_tmr_e state_q, state_d;
	logic [31:0] count_q, count_d;
	logic low_req;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		// zero threshold never defers
		low_req = i_req_valid && (i_threshold != ICSR_THR_OFF) &&
			(i_req_priority <= i_threshold);
		state_d = state_q;
		count_d = count_q;
		if (i_run) begin
			unique case (state_q)
				ICSR_TMR_IDLE: begin
					if (low_req) begin
						count_d = i_reload;
						state_d = (i_reload == ICSR_RST_WORD) ? ICSR_TMR_PASS : ICSR_TMR_COUNT;
					end
				end
				ICSR_TMR_COUNT: begin
					count_d = count_q - ICSR_TMR_ONE;
					if (count_q == ICSR_TMR_ONE) begin
						state_d = ICSR_TMR_PASS;
					end
				end
				ICSR_TMR_PASS: begin
					if (!low_req) begin
						state_d = ICSR_TMR_IDLE;
					end
				end
				default: begin
					state_d = ICSR_TMR_IDLE;
				end
			endcase
		end
		o_hold = low_req && (state_q != ICSR_TMR_PASS);
		o_busy = (state_q == ICSR_TMR_COUNT);
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			state_q <= ICSR_TMR_IDLE;
			count_q <= ICSR_RST_WORD;
		end else begin
			state_q <= state_d;
			count_q <= count_d;
		end
	end

endmodule

//--- icsr_top.sv
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - in single-vector mode with the shadow bit set, a presented vector carries a shadow set flag.
// - with the halt bit set and the core in debug mode, presentation and the timer stand still.
// - the halt bit takes writes only in debug mode and is forced to zero otherwise.
// - the multi-handler bit selects multi-vector mode when one, single-vector when zero.
// - a threshold n of 1 to 7 makes any request of priority n or lower start the timer.
// - a threshold of zero disables the timer so nothing is deferred.
// - each of five external inputs detects rising edges when its bit is one, falling when zero.
// - the status level field holds the priority of the latest presented request.
// - the status index field holds the six-bit vector of the latest presented request.
// - a triggering request loads the timer from the 32-bit reload register.
// - after reset all control bits, the reload value and the status fields are zero.
module icsr_top import icsr_pkg::*; (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic [ICSR_ADDR_W-1:0] i_awaddr,
	input wire logic [2:0] i_awprot,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [ICSR_ADDR_W-1:0] i_araddr,
	input wire logic [2:0] i_arprot,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_debug_mode,
	input wire logic [ICSR_NUM_EXT-1:0] i_ext_irq,
	input wire logic i_req_valid,
	input wire logic [ICSR_PRIO_W-1:0] i_req_priority,
	input wire logic [ICSR_VEC_W-1:0] i_req_vector,
	output logic [ICSR_NUM_EXT-1:0] o_ext_event,
	output logic o_cpu_irq,
	output logic [ICSR_PRIO_W-1:0] o_cpu_priority,
	output logic [ICSR_VEC_W-1:0] o_cpu_vector,
	output logic o_cpu_shadow_set,
	output logic o_multi_vector,
	output logic o_frozen
);

	// ****************************************
	// state
	// ****************************************
	logic shadow_q, shadow_d;
	logic halt_q, halt_d;
	logic multi_q, multi_d;
	logic [ICSR_PRIO_W-1:0] thr_q, thr_d;
	logic [ICSR_NUM_EXT-1:0] edge_sel_q, edge_sel_d;
	logic [31:0] reload_q, reload_d;
	logic [ICSR_PRIO_W-1:0] level_q, level_d;
	logic [ICSR_VEC_W-1:0] index_q, index_d;
	logic irq_q, irq_d;
	logic shadow_out_q, shadow_out_d;
	logic frozen_q, frozen_d;
	logic aw_hold_q, aw_hold_d;
	logic w_hold_q, w_hold_d;
	logic awready_q, awready_d;
	logic wready_q, wready_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic [ICSR_ADDR_W-1:0] waddr_q, waddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic arready_q, arready_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	logic [31:0] ctl_word, stat_word, merged;
	logic do_write, hold;
	logic [ICSR_NUM_EXT-1:0] ext_event;

	// ****************************************
	// submodules
	// ****************************************
	icsr_edge_detect u_edge (
		.i_clock(i_clock),
		.i_srst(i_srst),
		.i_pins(i_ext_irq),
		.i_rising_sel(edge_sel_q),
		.o_event(ext_event)
	);

	icsr_prox_timer u_timer (
		.i_clock(i_clock),
		.i_srst(i_srst),
		.i_run(~frozen_q),
		.i_threshold(thr_q),
		.i_reload(reload_q),
		.i_req_valid(i_req_valid),
		.i_req_priority(i_req_priority),
		.o_hold(hold),
		.o_busy()
	);

	// ****************************************
	// register views
	// ****************************************
	always_comb begin
		ctl_word = ICSR_RST_WORD;
		ctl_word[ICSR_CTL_SHADOW_BIT] = shadow_q;
		ctl_word[ICSR_CTL_HALT_BIT] = halt_q;
		ctl_word[ICSR_CTL_MULTI_BIT] = multi_q;
		ctl_word[ICSR_CTL_THR_LSB +: ICSR_PRIO_W] = thr_q;
		ctl_word[ICSR_CTL_EDGE_LSB +: ICSR_NUM_EXT] = edge_sel_q;
		stat_word = ICSR_RST_WORD;
		stat_word[ICSR_STAT_LEVEL_LSB +: ICSR_PRIO_W] = level_q;
		stat_word[ICSR_STAT_INDEX_LSB +: ICSR_VEC_W] = index_q;
	end

	// ****************************************
	// write channel
	// ****************************************
	always_comb begin
		aw_hold_d = aw_hold_q;
		w_hold_d = w_hold_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		if (i_awvalid && awready_q) begin
			aw_hold_d = 1'b1;
			waddr_d = i_awaddr;
		end
		if (i_wvalid && wready_q) begin
			w_hold_d = 1'b1;
			wdata_d = i_wdata;
			wstrb_d = i_wstrb;
		end
		if (bvalid_q && i_bready) begin
			bvalid_d = 1'b0;
		end
		do_write = aw_hold_q && w_hold_q && !bvalid_q;
		if (do_write) begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = (waddr_q == ICSR_OFF_CONTROL || waddr_q == ICSR_OFF_STATUS ||
				waddr_q == ICSR_OFF_RELOAD) ? ICSR_RESP_OKAY : ICSR_RESP_SLVERR;
		end
		awready_d = !aw_hold_d;
		wready_d = !w_hold_d;
		merged = ICSR_RST_WORD;
		for (int b = 0; b < 4; b++) begin
			merged[8*b +: 8] = wstrb_q[b] ? wdata_q[8*b +: 8] :
				((waddr_q == ICSR_OFF_RELOAD) ? reload_q[8*b +: 8] : ctl_word[8*b +: 8]);
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	always_comb begin
		shadow_d = shadow_q;
		halt_d = halt_q;
		multi_d = multi_q;
		thr_d = thr_q;
		edge_sel_d = edge_sel_q;
		reload_d = reload_q;
		if (do_write && waddr_q == ICSR_OFF_CONTROL) begin
			shadow_d = merged[ICSR_CTL_SHADOW_BIT];
			multi_d = merged[ICSR_CTL_MULTI_BIT];
			thr_d = merged[ICSR_CTL_THR_LSB +: ICSR_PRIO_W];
			edge_sel_d = merged[ICSR_CTL_EDGE_LSB +: ICSR_NUM_EXT];
			if (i_debug_mode) begin
				halt_d = merged[ICSR_CTL_HALT_BIT];
			end
		end
		if (!i_debug_mode) begin
			halt_d = 1'b0;
		end
		if (do_write && waddr_q == ICSR_OFF_RELOAD) begin
			reload_d = merged;
		end
		frozen_d = halt_d && i_debug_mode;
	end

	// ****************************************
	// presentation to the core
	// ****************************************
	always_comb begin
		irq_d = irq_q;
		level_d = level_q;
		index_d = index_q;
		shadow_out_d = shadow_out_q;
		if (!frozen_q) begin
			irq_d = i_req_valid && !hold;
			shadow_out_d = i_req_valid && !hold && shadow_q && !multi_q;
			if (i_req_valid && !hold) begin
				level_d = i_req_priority;
				index_d = i_req_vector;
			end
		end
	end

	// ****************************************
	// read channel
	// ****************************************
	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && i_rready) begin
			rvalid_d = 1'b0;
		end
		if (i_arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rresp_d = ICSR_RESP_OKAY;
			unique case (i_araddr)
				ICSR_OFF_CONTROL: rdata_d = ctl_word;
				ICSR_OFF_STATUS: rdata_d = stat_word;
				ICSR_OFF_RELOAD: rdata_d = reload_q;
				default: begin
					rdata_d = ICSR_RST_WORD;
					rresp_d = ICSR_RESP_SLVERR;
				end
			endcase
		end
		arready_d = !rvalid_d;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			// all zero after reset
			shadow_q <= 1'b0;
			halt_q <= 1'b0;
			multi_q <= 1'b0;
			thr_q <= ICSR_THR_OFF;
			edge_sel_q <= '0;
			reload_q <= ICSR_RST_WORD;
			level_q <= '0;
			index_q <= '0;
			irq_q <= 1'b0;
			shadow_out_q <= 1'b0;
			frozen_q <= 1'b0;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= ICSR_RESP_OKAY;
			waddr_q <= '0;
			wdata_q <= ICSR_RST_WORD;
			wstrb_q <= '0;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= ICSR_RST_WORD;
			rresp_q <= ICSR_RESP_OKAY;
		end else begin
			shadow_q <= shadow_d;
			halt_q <= halt_d;
			multi_q <= multi_d;
			thr_q <= thr_d;
			edge_sel_q <= edge_sel_d;
			reload_q <= reload_d;
			level_q <= level_d;
			index_q <= index_d;
			irq_q <= irq_d;
			shadow_out_q <= shadow_out_d;
			frozen_q <= frozen_d;
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign o_awready = awready_q;
	assign o_wready = wready_q;
	assign o_bvalid = bvalid_q;
	assign o_bresp = bresp_q;
	assign o_arready = arready_q;
	assign o_rvalid = rvalid_q;
	assign o_rdata = rdata_q;
	assign o_rresp = rresp_q;
	assign o_ext_event = ext_event;
	assign o_cpu_irq = irq_q;
	assign o_cpu_priority = level_q;
	assign o_cpu_vector = index_q;
	assign o_cpu_shadow_set = shadow_out_q;
	assign o_multi_vector = multi_q;
	assign o_frozen = frozen_q;

endmodule

//--- icsr_top_sva.sv
`timescale 1ns/1ps
module icsr_top_sva import icsr_pkg::*; (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_debug_mode,
	input wire logic i_req_valid,
	input wire logic [ICSR_PRIO_W-1:0] i_req_priority,
	input wire logic [ICSR_VEC_W-1:0] i_req_vector,
	input wire logic [ICSR_NUM_EXT-1:0] o_ext_event,
	input wire logic o_cpu_irq,
	input wire logic [ICSR_PRIO_W-1:0] o_cpu_priority,
	input wire logic [ICSR_VEC_W-1:0] o_cpu_vector,
	input wire logic o_cpu_shadow_set,
	input wire logic o_multi_vector,
	input wire logic o_frozen,
	input wire logic o_bvalid
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_srst);
	// ****
	// checks
	// ****
	sequence s_write_done;
		o_bvalid || $past(o_bvalid);
	endsequence
	a_shadow_with_irq: assert property (o_cpu_shadow_set |-> o_cpu_irq && !o_multi_vector)
		else $error("shadow flag outside single vector irq");
	a_frozen_holds: assert property (o_frozen |=> $stable(o_cpu_irq) && $stable(o_cpu_vector))
		else $error("outputs moved while frozen");
	a_frozen_needs_debug: assert property (o_frozen |-> $past(i_debug_mode))
		else $error("frozen outside debug mode");
	a_mode_by_write: assert property ($changed(o_multi_vector) |-> s_write_done)
		else $error("mode changed without a write");
	a_vec_from_req: assert property ($rose(o_cpu_irq) |->
		o_cpu_vector == $past(i_req_vector) && o_cpu_priority == $past(i_req_priority))
		else $error("presented vector or level not from request");
	a_irq_needs_req: assert property (o_cpu_irq && !$past(o_frozen) |-> $past(i_req_valid))
		else $error("irq without request");
	a_event_pulse: assert property (o_ext_event != 5'h00 |=> (o_ext_event & $past(o_ext_event)) == 5'h00)
		else $error("edge event wider than one cycle");
	a_reset_zero: assert property ($past(i_srst) |-> !o_cpu_irq && o_cpu_vector == 6'h00
		&& o_cpu_priority == 3'h0 && !o_multi_vector && !o_frozen)
		else $error("outputs not zero after reset");
endmodule
bind icsr_top icsr_top_sva u_sva (.i_clock, .i_srst, .i_debug_mode, .i_req_valid, .i_req_priority,
	.i_req_vector, .o_ext_event, .o_cpu_irq, .o_cpu_priority, .o_cpu_vector, .o_cpu_shadow_set,
	.o_multi_vector, .o_frozen, .o_bvalid);

//--- icsr_core_model.sv
`timescale 1ns/1ps
module icsr_core_model (
	input wire logic i_clock,
	input wire logic i_enter_debug,
	input wire logic i_cpu_irq,
	input wire logic [5:0] i_cpu_vector,
	output logic o_debug_mode,
	output logic [5:0] o_taken_vector
);
	// ****
	// core side
	// ****
	always_ff @(posedge i_clock) begin
		o_debug_mode <= i_enter_debug;
		if (i_cpu_irq) begin
			o_taken_vector <= i_cpu_vector;
		end
	end
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
	import icsr_pkg::*;
	localparam logic [1:0] OK = ICSR_RESP_OKAY;
	localparam logic [1:0] ER = ICSR_RESP_SLVERR;
	logic i_clock = 1'b0;
	logic i_srst = 1'b1;
	logic [3:0] i_awaddr = 4'h0, i_araddr = 4'h0;
	logic [31:0] i_wdata = 32'h0;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
	logic i_req_valid = 1'b0, dbg_req = 1'b0;
	logic [2:0] i_req_priority = 3'h0;
	logic [5:0] i_req_vector = 6'h00;
	logic [4:0] i_ext_irq = 5'h00;
	logic i_debug_mode, o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_cpu_irq;
	logic o_cpu_shadow_set, o_multi_vector, o_frozen;
	logic [1:0] o_bresp, o_rresp;
	logic [31:0] o_rdata;
	logic [4:0] o_ext_event;
	logic [2:0] o_cpu_priority;
	logic [5:0] o_cpu_vector, taken_vec;
	int fails = 0;
	int tests_run = 0;
	always #25 i_clock = ~i_clock;
	icsr_top DUT (.i_clock, .i_srst, .i_awaddr, .i_awprot(3'h0), .i_awvalid, .o_awready, .i_wdata,
		.i_wstrb(4'hF), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
		.i_arprot(3'h0), .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
		.i_debug_mode, .i_ext_irq, .i_req_valid, .i_req_priority, .i_req_vector, .o_ext_event,
		.o_cpu_irq, .o_cpu_priority, .o_cpu_vector, .o_cpu_shadow_set, .o_multi_vector, .o_frozen);
	icsr_core_model u_core (.i_clock, .i_enter_debug(dbg_req), .i_cpu_irq(o_cpu_irq),
		.i_cpu_vector(o_cpu_vector), .o_debug_mode(i_debug_mode), .o_taken_vector(taken_vec));
	// ****
	// tasks
	// ****
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge i_clock);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do begin
			@(posedge i_clock);
			n++;
			if (i_awvalid && o_awready) i_awvalid <= 1'b0;
			if (i_wvalid && o_wready) i_wvalid <= 1'b0;
		end while (!o_bvalid && n < 50);
		chk("bvalid", 1, o_bvalid);
		chk("bresp", r, o_bresp);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
		int n;
		n = 0;
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do begin
			@(posedge i_clock);
			n++;
			if (i_arvalid && o_arready) i_arvalid <= 1'b0;
		end while (!o_rvalid && n < 50);
		chk("rdata", e, o_rdata);
		chk("rresp", r, o_rresp);
	endtask
	task automatic present(input logic [2:0] p, input logic [5:0] v, input logic s, input int d);
		i_req_valid <= 1'b1;
		i_req_priority <= p;
		i_req_vector <= v;
		@(posedge i_clock);
		for (int j = 1; j <= d; j++) begin
			@(posedge i_clock);
			chk("irq", j == d, o_cpu_irq);
		end
		chk("prio", p, o_cpu_priority);
		chk("vec", v, o_cpu_vector);
		chk("shadow", s, o_cpu_shadow_set);
		i_req_valid <= 1'b0;
		cyc(3);
	endtask
	task automatic edges(input logic [4:0] pins, input logic [4:0] e);
		logic [4:0] acc;
		acc = 5'h00;
		i_ext_irq <= pins;
		repeat (8) begin
			@(posedge i_clock);
			acc = acc | o_ext_event;
		end
		chk("events", e, acc);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ****
	// sequence
	// ****
	initial begin
		#100us;
		fails++;
		summarize;
	end
	initial begin
		cyc(4);
		i_srst <= 1'b0;
		cyc(2);
		rd(ICSR_OFF_CONTROL, 32'h0, OK);
		rd(ICSR_OFF_STATUS, 32'h0, OK);
		rd(ICSR_OFF_RELOAD, 32'h0, OK);
		wr(ICSR_OFF_CONTROL, 32'h0001_571F, OK);
		rd(ICSR_OFF_CONTROL, 32'h0001_171F, OK);
		chk("multi", 1, o_multi_vector);
		wr(4'hC, 32'h0000_0001, ER);
		rd(4'hC, 32'h0, ER);
		wr(ICSR_OFF_STATUS, 32'h0000_0FFF, OK);
		rd(ICSR_OFF_STATUS, 32'h0, OK);
		wr(ICSR_OFF_CONTROL, 32'h0001_0000, OK);
		chk("multi", 0, o_multi_vector);
		present(3'h5, 6'h2A, 1'b1, 1);
		rd(ICSR_OFF_STATUS, 32'h0000_052A, OK);
		chk("core vec", 6'h2A, taken_vec);
		wr(ICSR_OFF_RELOAD, 32'h0000_0003, OK);
		rd(ICSR_OFF_RELOAD, 32'h0000_0003, OK);
		wr(ICSR_OFF_CONTROL, 32'h0000_0200, OK);
		present(3'h1, 6'h11, 1'b0, 5);
		present(3'h2, 6'h12, 1'b0, 5);
		present(3'h3, 6'h13, 1'b0, 1);
		wr(ICSR_OFF_CONTROL, 32'h0000_0100, OK);
		present(3'h1, 6'h14, 1'b0, 5);
		present(3'h2, 6'h15, 1'b0, 1);
		wr(ICSR_OFF_RELOAD, 32'h0, OK);
		present(3'h1, 6'h16, 1'b0, 2);
		wr(ICSR_OFF_CONTROL, 32'h0000_0015, OK);
		edges(5'h1F, 5'h15);
		edges(5'h00, 5'h0A);
		dbg_req <= 1'b1;
		cyc(2);
		wr(ICSR_OFF_CONTROL, 32'h0000_4000, OK);
		rd(ICSR_OFF_CONTROL, 32'h0000_4000, OK);
		cyc(2);
		chk("frozen", 1, o_frozen);
		i_req_valid <= 1'b1;
		i_req_priority <= 3'h4;
		i_req_vector <= 6'h05;
		cyc(4);
		chk("irq", 0, o_cpu_irq);
		dbg_req <= 1'b0;
		cyc(4);
		chk("irq", 1, o_cpu_irq);
		chk("frozen", 0, o_frozen);
		rd(ICSR_OFF_CONTROL, 32'h0, OK);
		i_req_valid <= 1'b0;
		cyc(3);
		summarize;
	end
endmodule
